// ---- rtl/pwt_ctrl_pkg.sv ----
// package: register map, field positions and types for the pulse width timer control block
package pwt_ctrl_pkg;
   localparam logic [3:0]  CTRL_STATUS_OFFSET = 4'h0;
   localparam logic [3:0]  WIDTHS_OFFSET      = 4'h4;
   localparam int          HIGH_WIDTH_LSB     = 16;
   localparam int          CLK_SRC_BIT        = 15;
   localparam int          INPUT_SEL_LSB      = 13;
   localparam int          EDGE_LSB           = 11;
   localparam int          PRESCALE_LSB       = 8;
   localparam int          MODULE_ON_BIT      = 7;
   localparam int          IRQ_MASTER_BIT     = 6;
   localparam int          IRQ_VALID_BIT      = 5;
   localparam int          IRQ_WRAP_BIT       = 4;
   localparam int          SOFT_RESTART_BIT   = 3;
   localparam int          RESERVED_BIT       = 2;
   localparam int          VALID_FLAG_BIT     = 1;
   localparam int          WRAP_FLAG_BIT      = 0;
   localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
   localparam logic [31:0] CTRL_WRITABLE      = 32'h0000_FFF0;
   localparam logic [1:0]  EDGE_FALL_FALL     = 2'h0;
   localparam logic [1:0]  EDGE_RISE_BOTH     = 2'h1;
   localparam logic [1:0]  EDGE_FALL_BOTH     = 2'h2;
   localparam logic [1:0]  EDGE_RISE_RISE     = 2'h3;
   localparam logic [2:0]  PRESCALE_DIV16     = 3'h4;
   localparam logic [2:0]  PRESCALE_DIV128    = 3'h7;

   typedef struct packed {
      logic        clk_src;
      logic [1:0]  input_sel;
      logic [1:0]  edge_sel;
      logic [2:0]  prescale;
      logic        module_on;
      logic        irq_master_allow;
      logic        irq_on_width_valid;
      logic        irq_on_wrap;
   } cfg_s;

   typedef struct packed {
      logic high_update;
      logic low_update;
      logic wrap;
   } event_s;
endpackage

// ---- rtl/pwt_prescaler.sv ----
// prescaler: one-cycle counter-advance enable, divide by 2**code
`timescale 1ns/100ps
`default_nettype none
module pwt_prescaler
(
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   input  wire logic       i_clear,
   input  wire logic [2:0] i_code,
   output logic            o_tick
);
   typedef struct packed {
      logic [6:0] cnt;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   logic [6:0] mask;

   always_comb
   begin
      mask   = 7'((8'h01 << i_code) - 8'h01);
      st_nxt = st_r;
      o_tick = ((st_r.cnt & mask) == mask);
      if (i_clear)
      begin
         st_nxt.cnt = 7'h00;
         o_tick     = 1'b0;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         st_r <= '{cnt: 7'h00};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_DIV128_GAP: assert property (@(posedge i_clk) disable iff (i_srst)
      (o_tick && i_code == 3'h7 && !i_clear) ##1 (!i_clear && i_code == 3'h7) [*8]
      |-> !o_tick)
      else $error("divide-by-128 tick came too early");
endmodule
`default_nettype wire

// ---- rtl/pwt_ctrl_status.sv ----
// pulse width timer control/status register with counter, capture and interrupt
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - prescaler codes 100..111 divide the counter clock by 16, 32, 64, 128
// - module_on bit 7: 0 disables the timer, 1 enables it
// - irq_master_allow bit 6 gates every interrupt
// - bit 5 enables interrupt on width_valid_flag under master enable
// - bit 4 enables interrupt on counter_wrap_flag
// - writing 1 to bit 3 soft-restarts the timer; reads zero
// - bit 2 reserved, reads zero
// - bit 1 set when captured widths are updated and readable
// - width_valid_flag clears by read-while-set then write 0; write 1 ignored
// - width_valid_flag set condition depends on edge selection
// - counter_wrap_flag sets when the 16-bit counter wraps FFFF to 0
// - writing 0 clears counter_wrap_flag; writing 1 leaves it
// - wrap in the clearing cycle keeps counter_wrap_flag set
// - edge codes 00,11,01,10 select which update sequence sets width_valid_flag
// - soft restart zeroes counter, prescaler, edge logic, widths and flags only
// - read buffers hold while width_valid_flag set; widths keep updating
module pwt_ctrl_status
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic [3:0]  i_pulse_in,
   input  wire logic        i_alt_tick,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_wb_err,
   output logic             o_irq
);
   typedef struct packed {
      pwt_ctrl_pkg::cfg_s cfg;
      logic               valid_flag;
      logic               wrap_flag;
      logic               valid_seen;
      logic [15:0]        count;
      logic [15:0]        high_width;
      logic [15:0]        low_width;
      logic [15:0]        high_buf;
      logic [15:0]        low_buf;
      logic               armed;
      logic               half_done;
      logic [3:0]         pin_sync0;
      logic [3:0]         pin_meta;
      logic               pin_prev;
      logic               ack;
      logic [31:0]        rdata;
      logic               irq;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   pwt_ctrl_pkg::event_s ev;
   logic        pre_tick;
   logic        pre_clear;
   logic        adv;
   logic        pin_now;
   logic        rise;
   logic        fall;
   logic        run;
   logic        soft_restart;
   logic        wr_ctrl;
   logic        rd_ctrl;
   logic        rd_wid;
   logic        hit;
   logic        trig;
   logic        cap;
   logic [31:0] ctrl_view;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] cfg_word;

   pwt_prescaler u_prescaler
   (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_clear (pre_clear),
      .i_code  (st_r.cfg.prescale),
      .o_tick  (pre_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_nxt  = st_r;
      hit     = i_wb_cyc && i_wb_stb && !st_r.ack;
      wr_ctrl = hit && i_wb_we && i_wb_adr == pwt_ctrl_pkg::CTRL_STATUS_OFFSET;
      rd_ctrl = hit && !i_wb_we && i_wb_adr == pwt_ctrl_pkg::CTRL_STATUS_OFFSET;
      rd_wid  = hit && !i_wb_we && i_wb_adr == pwt_ctrl_pkg::WIDTHS_OFFSET;
      wmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
      wval    = i_wb_dat;
      soft_restart = wr_ctrl && i_wb_sel[0]
                     && wval[pwt_ctrl_pkg::SOFT_RESTART_BIT];
      run     = st_r.cfg.module_on;
      // selected pin: sync stage 2 only; first stage feeds nothing else
      pin_now = st_r.pin_sync0[st_r.cfg.input_sel];
      rise    = run && pin_now && !st_r.pin_prev;
      fall    = run && !pin_now && st_r.pin_prev;
      trig    = 1'b0;
      cap     = 1'b0;
      ev      = '0;
      unique case (st_r.cfg.edge_sel)
         pwt_ctrl_pkg::EDGE_FALL_FALL:
         begin
            trig           = fall;
            ev.high_update = fall;
         end
         pwt_ctrl_pkg::EDGE_RISE_RISE:
         begin
            trig          = rise;
            ev.low_update = rise;
         end
         pwt_ctrl_pkg::EDGE_RISE_BOTH:
         begin
            trig           = rise;
            ev.high_update = fall;
            ev.low_update  = rise;
         end
         pwt_ctrl_pkg::EDGE_FALL_BOTH:
         begin
            trig           = fall;
            ev.high_update = fall;
            ev.low_update  = rise;
         end
      endcase
      if (!st_r.armed)
      begin
         ev = '0;
      end
      cap       = ev.high_update || ev.low_update;
      pre_clear = !run || soft_restart || cap || (trig && !st_r.armed);
      // counter free-runs from enable; the trigger edge only restarts it
      adv       = run && pre_tick
                  && (st_r.cfg.clk_src ? i_alt_tick : 1'b1);
      ev.wrap   = adv && !cap && st_r.count == 16'hFFFF;

      // pin synchroniser
      st_nxt.pin_meta  = i_pulse_in;
      st_nxt.pin_sync0 = st_r.pin_meta;
      st_nxt.pin_prev  = pin_now;

      // counter and capture
      if (trig && !st_r.armed)
      begin
         st_nxt.armed = 1'b1;
         st_nxt.count = 16'h0000;
      end
      else if (cap)
      begin
         st_nxt.count = 16'h0000;
      end
      else if (adv)
      begin
         st_nxt.count = st_r.count + 16'h0001;
      end
      if (ev.high_update)
      begin
         st_nxt.high_width = st_r.count;
      end
      if (ev.low_update)
      begin
         st_nxt.low_width = st_r.count;
      end

      // ready sequencing: single-edge modes set at once, dual modes need two halves
      if (cap)
      begin
         unique case (st_r.cfg.edge_sel)
            pwt_ctrl_pkg::EDGE_FALL_FALL,
            pwt_ctrl_pkg::EDGE_RISE_RISE:
               st_nxt.valid_flag = 1'b1;
            pwt_ctrl_pkg::EDGE_RISE_BOTH:
            begin
               if (ev.high_update) st_nxt.half_done = 1'b1;
               if (ev.low_update && st_r.half_done)
               begin
                  st_nxt.valid_flag = 1'b1;
                  st_nxt.half_done  = 1'b0;
               end
            end
            pwt_ctrl_pkg::EDGE_FALL_BOTH:
            begin
               if (ev.low_update) st_nxt.half_done = 1'b1;
               if (ev.high_update && st_r.half_done)
               begin
                  st_nxt.valid_flag = 1'b1;
                  st_nxt.half_done  = 1'b0;
               end
            end
         endcase
      end

      // read buffers follow widths only while the flag is clear
      if (!st_r.valid_flag)
      begin
         st_nxt.high_buf = st_nxt.high_width;
         st_nxt.low_buf  = st_nxt.low_width;
      end

      // register view
      ctrl_view = {st_r.high_buf, st_r.cfg.clk_src, st_r.cfg.input_sel,
                   st_r.cfg.edge_sel, st_r.cfg.prescale, st_r.cfg.module_on,
                   st_r.cfg.irq_master_allow, st_r.cfg.irq_on_width_valid,
                   st_r.cfg.irq_on_wrap, 1'b0, 1'b0,
                   st_r.valid_flag, st_r.wrap_flag};
      if (rd_ctrl && st_r.valid_flag)
      begin
         st_nxt.valid_seen = 1'b1;
      end
      cfg_word = (ctrl_view & ~(wmask & pwt_ctrl_pkg::CTRL_WRITABLE))
                 | (wval & wmask & pwt_ctrl_pkg::CTRL_WRITABLE);
      if (wr_ctrl)
      begin
         st_nxt.cfg = pwt_ctrl_pkg::cfg_s'(cfg_word[pwt_ctrl_pkg::CLK_SRC_BIT:
                                                    pwt_ctrl_pkg::IRQ_WRAP_BIT]);
         if (i_wb_sel[0] && !wval[pwt_ctrl_pkg::VALID_FLAG_BIT]
             && st_r.valid_seen && !cap)
         begin
            st_nxt.valid_flag = 1'b0;
            st_nxt.valid_seen = 1'b0;
         end
         if (i_wb_sel[0] && !wval[pwt_ctrl_pkg::WRAP_FLAG_BIT])
         begin
            st_nxt.wrap_flag = 1'b0;
         end
      end
      if (ev.wrap)
      begin
         st_nxt.wrap_flag = 1'b1;
      end

      // soft restart or disabled: clear datapath, keep configuration
      if (soft_restart || !run)
      begin
         st_nxt.count      = 16'h0000;
         st_nxt.high_width = 16'h0000;
         st_nxt.low_width  = 16'h0000;
         st_nxt.high_buf   = 16'h0000;
         st_nxt.low_buf    = 16'h0000;
         st_nxt.armed      = 1'b0;
         st_nxt.half_done  = 1'b0;
         st_nxt.valid_flag = 1'b0;
         st_nxt.valid_seen = 1'b0;
         st_nxt.wrap_flag  = 1'b0;
      end

      // bus answer one cycle after request; unmapped reads return zero
      st_nxt.ack   = hit;
      st_nxt.rdata = rd_ctrl ? ctrl_view
                   : rd_wid ? {st_r.count, st_r.low_buf} : 32'h0000_0000;
      st_nxt.irq   = st_nxt.cfg.irq_master_allow
                     && ((st_nxt.valid_flag && st_nxt.cfg.irq_on_width_valid)
                     || (st_nxt.wrap_flag && st_nxt.cfg.irq_on_wrap));
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_wb_dat = st_r.rdata;
   assign o_wb_ack = st_r.ack;
   assign o_wb_err = 1'b0;
   assign o_irq    = st_r.irq;

   ////////////////////////////////////////////////////////////////////////////
   AST_IRQ_MASTER_GATE: assert property (@(posedge i_clk) disable iff (i_srst)
      !st_r.cfg.irq_master_allow |-> !o_irq)
      else $error("interrupt raised with master enable clear");
   AST_IRQ_VALID: assert property (@(posedge i_clk) disable iff (i_srst)
      (st_r.cfg.irq_master_allow && st_r.cfg.irq_on_width_valid && st_r.valid_flag)
      |-> o_irq)
      else $error("ready interrupt missing");
   AST_IRQ_WRAP: assert property (@(posedge i_clk) disable iff (i_srst)
      (st_r.cfg.irq_master_allow && st_r.cfg.irq_on_wrap && st_r.wrap_flag) |-> o_irq)
      else $error("wrap interrupt missing");
   AST_IRQ_CAUSE: assert property (@(posedge i_clk) disable iff (i_srst)
      o_irq |-> (st_r.valid_flag && st_r.cfg.irq_on_width_valid)
                || (st_r.wrap_flag && st_r.cfg.irq_on_wrap))
      else $error("interrupt without enabled flag");
   AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (i_srst)
      $rose(o_wb_ack) && $past(rd_ctrl) |-> o_wb_dat[3:2] == 2'h0)
      else $error("reserved or restart bit read nonzero");
   AST_WRAP_SETS: assert property (@(posedge i_clk) disable iff (i_srst)
      (ev.wrap && !soft_restart && run) |=> st_r.wrap_flag && st_r.count == 16'h0000)
      else $error("wrap did not set flag");
   AST_WRAP_WINS: assert property (@(posedge i_clk) disable iff (i_srst)
      (ev.wrap && wr_ctrl && run && !soft_restart) |=> st_r.wrap_flag)
      else $error("clear beat a simultaneous wrap");
   AST_VALID_NO_SET_BY_WRITE: assert property (@(posedge i_clk) disable iff (i_srst)
      (!st_r.valid_flag && !cap) |=> !st_r.valid_flag)
      else $error("ready flag set without capture");
   AST_SOFT_RESTART: assert property (@(posedge i_clk) disable iff (i_srst)
      soft_restart |=> !st_r.valid_flag && !st_r.wrap_flag && st_r.count == 16'h0000
                       && st_r.cfg == $past(st_nxt.cfg))
      else $error("soft restart wrong");
   AST_BUF_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
      (st_r.valid_flag && !soft_restart && run) |=> $stable(st_r.high_buf))
      else $error("read buffer changed while ready set");
   AST_DISABLED_IDLE: assert property (@(posedge i_clk) disable iff (i_srst)
      !run [*2] |-> st_r.count == 16'h0000 && !st_r.armed)
      else $error("counter runs while disabled");
   COV_WRAP: cover property (@(posedge i_clk) disable iff (i_srst) ev.wrap);
   COV_READY: cover property (@(posedge i_clk) disable iff (i_srst) $rose(st_r.valid_flag));
   COV_IRQ: cover property (@(posedge i_clk) disable iff (i_srst) $rose(o_irq));
endmodule
`default_nettype wire

// ---- tb/pulse_width_timer_ctrl_status_test.sv ----
// testbench: bus-driven checks of the timer control and status register
`timescale 1ns/100ps
`default_nettype none
module pulse_width_timer_ctrl_status_test;
   logic        i_clk      = 1'b0;
   logic        i_srst     = 1'b1;
   logic [3:0]  i_pulse_in = 4'h0;
   logic        i_alt_tick = 1'b0;
   logic        i_wb_cyc   = 1'b0;
   logic        i_wb_stb   = 1'b0;
   logic        i_wb_we    = 1'b0;
   logic [3:0]  i_wb_adr   = 4'h0;
   logic [3:0]  i_wb_sel   = 4'h0;
   logic [31:0] i_wb_dat   = 32'h0000_0000;
   logic [31:0] o_wb_dat;
   logic        o_wb_ack;
   logic        o_wb_err;
   logic        o_irq;
   int          err_count  = 0;
   int          n_compared = 0;
   int          cnt        = 0;
   int          tk;
   int          t1;
   int          n;
   logic [31:0] seed       = 32'h0000_0005;
   logic [31:0] rd;
   logic [31:0] cfg;
   logic [15:0] c1;

   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) cnt <= cnt + 1;

   pwt_ctrl_status pwt_ctrl_status_i
   (
      .i_clk      (i_clk),
      .i_srst     (i_srst),
      .i_pulse_in (i_pulse_in),
      .i_alt_tick (i_alt_tick),
      .i_wb_cyc   (i_wb_cyc),
      .i_wb_stb   (i_wb_stb),
      .i_wb_we    (i_wb_we),
      .i_wb_adr   (i_wb_adr),
      .i_wb_sel   (i_wb_sel),
      .i_wb_dat   (i_wb_dat),
      .o_wb_dat   (o_wb_dat),
      .o_wb_ack   (o_wb_ack),
      .o_wb_err   (o_wb_err),
      .o_irq      (o_irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // input select is random: all four inputs carry the same pulse train
   function automatic logic [31:0] mk(input logic on, input logic [2:0] pre,
                                      input logic [1:0] ed, input logic [2:0] ie);
      logic [31:0] r;
      r = xs();
      return {16'h0000, 1'b0, r[1:0], ed, pre, on, ie, 4'h0};
   endfunction

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %b seen %b", what, exp, got);
         err_count++;
      end
   endtask

   // one classic cycle; the edge that raises the request is kept in tk
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      int w;
      w = 0;
      @(posedge i_clk);
      tk = cnt;
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= we;
      i_wb_adr <= adr;
      i_wb_sel <= 4'hF;
      i_wb_dat <= wd;
      do
      begin
         @(posedge i_clk);
         w++;
      end
      while (o_wb_ack !== 1'b1 && w < 100);
      if (w >= 100)
         chk_bit("bus ack", 1'b1, 1'b0);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (90000) @(posedge i_clk);
      err_count++;
      summarize();
   end

   initial
   begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      chk_word("reset ctrl", pwt_ctrl_pkg::CTRL_RESET, rd);
      chk_bit("bus err", 1'b0, o_wb_err);
      wb(1'b1, 4'hC, 32'hFFFF_FFFF);
      wb(1'b0, 4'h8, 32'h0);
      chk_word("unmapped read", 32'h0, rd);
      wb(1'b1, 4'h0, 32'h0000_000F);
      wb(1'b0, 4'h0, 32'h0);
      chk_word("low nibble write", 32'h0, rd);
      // counter advance over exactly four prescaled periods
      for (int k = 0; k < 8; k++)
      begin
         if (k > 0)
         begin
            cfg[7] = 1'b0;
            wb(1'b1, 4'h0, cfg);
         end
         cfg = mk(1'b0, k[2:0], 2'h0, 3'h0);
         wb(1'b1, 4'h0, cfg);
         cfg[7] = 1'b1;
         wb(1'b1, 4'h0, cfg);
         wb(1'b0, 4'h4, 32'h0);
         c1 = rd[31:16];
         t1 = tk;
         while (cnt + 1 != t1 + (4 << k)) @(posedge i_clk);
         wb(1'b0, 4'h4, 32'h0);
         chk_word("counter step", 32'h0000_0004, {16'h0, rd[31:16] - c1});
      end
      // divide by 128: counter still 0 just after the restart
      wb(1'b1, 4'h0, cfg | 32'h8);
      wb(1'b0, 4'h4, 32'h0);
      chk_word("counter after restart", 32'h0, rd);
      wb(1'b0, 4'h0, 32'h0);
      chk_word("cfg after restart", cfg, {16'h0, rd[15:0]});
      cfg[7] = 1'b0;
      wb(1'b1, 4'h0, cfg);
      repeat (20) @(posedge i_clk);
      wb(1'b0, 4'h4, 32'h0);
      chk_word("counter while off", 32'h0, rd);
      // free run at divide by 1 until the counter wraps
      cfg = mk(1'b0, 3'h0, 2'h0, 3'h5);
      wb(1'b1, 4'h0, cfg);
      cfg[7] = 1'b1;
      wb(1'b1, 4'h0, cfg);
      n = 0;
      while (o_irq !== 1'b1 && n < 70000)
      begin
         @(posedge i_clk);
         n++;
      end
      chk_bit("wrap timing", 1'b1, n >= 65530 && n <= 65545);
      wb(1'b1, 4'h0, cfg | 32'h1);
      wb(1'b0, 4'h0, 32'h0);
      chk_word("wrap flag kept", cfg | 32'h1, {16'h0, rd[15:0]});
      cfg[6] = 1'b0;
      wb(1'b1, 4'h0, cfg | 32'h1);
      repeat (2) @(posedge i_clk);
      chk_bit("irq master off", 1'b0, o_irq);
      cfg[6] = 1'b1;
      cfg[4] = 1'b0;
      wb(1'b1, 4'h0, cfg | 32'h1);
      repeat (2) @(posedge i_clk);
      chk_bit("irq wrap off", 1'b0, o_irq);
      cfg[4] = 1'b1;
      wb(1'b1, 4'h0, cfg);
      wb(1'b0, 4'h0, 32'h0);
      chk_word("wrap flag cleared", cfg, {16'h0, rd[15:0]});
      chk_bit("irq after clear", 1'b0, o_irq);
      cfg[7] = 1'b0;
      wb(1'b1, 4'h0, cfg);
      // every edge mode must raise the valid flag on a pulse train
      for (int e = 0; e < 4; e++)
      begin
         cfg = mk(1'b0, 3'h0, e[1:0], 3'h6);
         wb(1'b1, 4'h0, cfg);
         cfg[7] = 1'b1;
         wb(1'b1, 4'h0, cfg);
         repeat (8)
         begin
            repeat (20) @(posedge i_clk);
            i_pulse_in <= ~i_pulse_in;
         end
         repeat (10) @(posedge i_clk);
         wb(1'b1, 4'h0, cfg);
         wb(1'b0, 4'h0, 32'h0);
         chk_word("valid flag", cfg | 32'h2, {16'h0, rd[15:0]});
         chk_bit("irq on valid", 1'b1, o_irq);
         wb(1'b1, 4'h0, cfg);
         wb(1'b0, 4'h0, 32'h0);
         chk_word("valid cleared", cfg, {16'h0, rd[15:0]});
         repeat (2) @(posedge i_clk);
         chk_bit("irq valid cleared", 1'b0, o_irq);
         cfg[7] = 1'b0;
         wb(1'b1, 4'h0, cfg);
      end
      summarize();
   end
endmodule
`default_nettype wire
